// ---- hw/ufss_pkg.sv ----
// Package for the user flash sector store access logic.
// Assumes a single 50 MHz ref_clk domain and synchronous active-low reset.
package ufss_pkg;
   localparam int unsigned TOTAL_BITS = 8192;
   localparam int unsigned SECTOR_BITS = 4096;
   localparam int unsigned NUM_SECTORS = 2;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned WORDS = 512;
   localparam int unsigned SECTOR_WORDS = 256;
   localparam logic [8:0] ADDR_MAX = 9'h1ff;
   localparam logic [8:0] SECTOR1_BASE = 9'h100;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam logic [8:0] ADDR_RESET = 9'h000;
   localparam logic [4:0] BITCNT_RESET = 5'h00;
   // Busy time of one program or erase, in cycles
   localparam logic [7:0] PROG_CYCLES = 8'h08;
   localparam logic [7:0] ERASE_CYCLES = 8'h40;
   // Serial command opcodes, sent msb first
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_PROG = 2'h1;
   localparam logic [1:0] CMD_ERASE = 2'h2;
   localparam logic [1:0] CMD_SETADDR = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SHIFT = 3'b001,
      ST_EXEC = 3'b010,
      ST_OUT = 3'b011,
      ST_BUSY = 3'b100
   } ufss_state_e;
endpackage

// ---- hw/ufss_store.sv ----
// User flash sector store: array, serial port and access sequencer.
// Assumes user logic drives the serial inputs from ref_clk-domain logic.
//
// Operation
// - 8192 bits in two 4096-bit sectors
// - 512 words, 9-bit address 000h to 1FFh
// - 000h to 0FFh is sector zero
// - 100h to 1FFh is sector one
// - Sixteen-bit data word per location
// - Narrower user widths adapted around store
// - Erase one whole sector at once
// - Serial port reads and writes data
`timescale 1ns/1ps
module ufss_store #(
   parameter int unsigned USER_W = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Serial command port
   input wire logic serEn,
   input wire logic serIn,
   output logic serOut,
   output logic serOutValid,
   // Status
   output logic busy,
   output logic [8:0] curAddr
);
   localparam int unsigned SHW = 2 + 16;
   // Flash array, erased state all ones
   logic [15:0] mem [0:511];
   ufss_pkg::ufss_state_e state, next_state;
   logic [17:0] shreg, next_shreg;
   logic [4:0] bitCnt, next_bitCnt;
   logic [7:0] busyCnt, next_busyCnt;
   logic [8:0] next_curAddr;
   logic [15:0] outReg, next_outReg;
   logic next_serOut, next_serOutValid;
   logic [1:0] op, next_op;
   logic memWr, memErase;
   logic eraseSector;
   logic [15:0] rdWord, wrWord;
   logic [USER_W-1:0] userRd;

   ufss_width_adapt #(.USER_W(USER_W)) adapt (
      .storeRdata(rdWord),
      .storeWdata(wrWord),
      .userWdata(shreg[USER_W-1:0]),
      .userRdata(userRd)
   );

   assign rdWord = mem[curAddr];
   assign eraseSector = curAddr[8];

   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bitCnt = bitCnt;
      next_busyCnt = busyCnt;
      next_curAddr = curAddr;
      next_outReg = outReg;
      next_serOut = 1'b0;
      next_serOutValid = 1'b0;
      next_op = op;
      memWr = 1'b0;
      memErase = 1'b0;
      case (state)
         ufss_pkg::ST_IDLE: begin
            if (serEn) begin
               next_shreg = {shreg[16:0], serIn};
               next_bitCnt = 5'h01;
               next_state = ufss_pkg::ST_SHIFT;
            end
         end
         ufss_pkg::ST_SHIFT: begin
            if (serEn) begin
               next_shreg = {shreg[16:0], serIn};
               next_bitCnt = bitCnt + 5'h01;
               if (bitCnt == 5'(SHW - 1)) next_state = ufss_pkg::ST_EXEC;
            end
         end
         ufss_pkg::ST_EXEC: begin
            next_op = shreg[17:16];
            next_bitCnt = ufss_pkg::BITCNT_RESET;
            case (shreg[17:16])
               ufss_pkg::CMD_READ: begin
                  next_outReg = 16'(userRd);
                  next_curAddr = curAddr + 9'h001;
                  next_state = ufss_pkg::ST_OUT;
               end
               ufss_pkg::CMD_PROG: begin
                  memWr = 1'b1;
                  next_busyCnt = ufss_pkg::PROG_CYCLES;
                  next_state = ufss_pkg::ST_BUSY;
               end
               ufss_pkg::CMD_ERASE: begin
                  memErase = 1'b1;
                  next_busyCnt = ufss_pkg::ERASE_CYCLES;
                  next_state = ufss_pkg::ST_BUSY;
               end
               default: begin
                  next_curAddr = shreg[8:0];
                  next_state = ufss_pkg::ST_IDLE;
               end
            endcase
         end
         ufss_pkg::ST_OUT: begin
            next_serOut = outReg[15];
            next_serOutValid = 1'b1;
            next_outReg = {outReg[14:0], 1'b0};
            next_bitCnt = bitCnt + 5'h01;
            if (bitCnt == 5'h0f) next_state = ufss_pkg::ST_IDLE;
         end
         ufss_pkg::ST_BUSY: begin
            next_busyCnt = busyCnt - 8'h01;
            if (busyCnt == 8'h01) begin
               next_state = ufss_pkg::ST_IDLE;
               // Program advances the address, erase does not
               if (op == ufss_pkg::CMD_PROG)
                  next_curAddr = curAddr + 9'h001;
            end
         end
         default: next_state = ufss_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= ufss_pkg::ST_IDLE;
         shreg <= '0;
         bitCnt <= ufss_pkg::BITCNT_RESET;
         busyCnt <= 8'h00;
         curAddr <= ufss_pkg::ADDR_RESET;
         outReg <= 16'h0000;
         serOut <= 1'b0;
         serOutValid <= 1'b0;
         op <= ufss_pkg::CMD_READ;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         bitCnt <= next_bitCnt;
         busyCnt <= next_busyCnt;
         curAddr <= next_curAddr;
         outReg <= next_outReg;
         serOut <= next_serOut;
         serOutValid <= next_serOutValid;
         op <= next_op;
      end
   end

   // Array has no reset: contents are non-volatile
   // Program only clears bits, as flash does
   always_ff @(posedge ref_clk) begin
      if (memWr) mem[curAddr] <= mem[curAddr] & wrWord;
      if (memErase) begin
         for (int i = 0; i < 256; i++) begin
            mem[{eraseSector, 8'(i)}] <= ufss_pkg::ERASED_WORD;
         end
      end
   end

   assign busy = (state != ufss_pkg::ST_IDLE);

   // Assertions
   // Busy span: exec cycle, then the count of the operation
   prog_busy_len_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      memWr |=> busy [*8] ##1 !busy)
      else $error("program busy length wrong");
   erase_busy_len_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      memErase |=> busy [*8] ##57 !busy)
      else $error("erase busy length wrong");
   erase_addr_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      memErase |=> curAddr == $past(curAddr))
      else $error("erase moved the address");

   // Address stepping and loading
   read_incr_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ufss_pkg::ST_EXEC && shreg[17:16] == ufss_pkg::CMD_READ)
      |=> curAddr == $past(curAddr) + 9'h001)
      else $error("read address not incremented");
   prog_incr_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      memWr |-> ##9 curAddr == $past(curAddr, 9) + 9'h001)
      else $error("program address not incremented");
   setaddr_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ufss_pkg::ST_EXEC && shreg[17:16] == ufss_pkg::CMD_SETADDR)
      |=> curAddr == $past(shreg[8:0]))
      else $error("address load wrong");

   // Serial port behaviour
   read_out_len_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(serOutValid) |-> serOutValid [*8] ##1 serOutValid [*8]
      ##1 !serOutValid)
      else $error("read output not 16 bits");
   busy_ignore_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ufss_pkg::ST_BUSY) |=> $stable(shreg))
      else $error("input taken while busy");

   // Sector bounds and erased contents
   erase_sector_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      memErase |=>
      mem[$past(curAddr) & 9'h100] == ufss_pkg::ERASED_WORD &&
      mem[$past(curAddr) | 9'h0ff] == ufss_pkg::ERASED_WORD)
      else $error("erase sector mismatch");
   erased_read_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      memErase |=> mem[$past(curAddr)] == ufss_pkg::ERASED_WORD)
      else $error("erased word not all ones");

   // Narrow widths leave upper bits erased
   narrow_pad_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      memWr |-> (wrWord >> USER_W) == (16'hffff >> USER_W))
      else $error("upper program bits not ones");

   read_c: cover property (@(posedge ref_clk) $rose(serOutValid));
   prog_c: cover property (@(posedge ref_clk) memWr);
   erase0_c: cover property (@(posedge ref_clk) memErase && !eraseSector);
   erase1_c: cover property (@(posedge ref_clk) memErase && eraseSector);
   wrap_c: cover property (@(posedge ref_clk)
      curAddr == ufss_pkg::ADDR_MAX ##[1:100] curAddr == 9'h000);
endmodule // ufss_store

// ---- hw/ufss_width_adapt.sv ----
// Narrow-word adapter between the user width and the 16-bit store word.
// Assumes a combinational path inside the ref_clk domain.
`timescale 1ns/1ps
module ufss_width_adapt #(
   parameter int unsigned USER_W = 16
) (
   // Store side
   input wire logic [15:0] storeRdata,
   output logic [15:0] storeWdata,
   // User side
   input wire logic [USER_W-1:0] userWdata,
   output logic [USER_W-1:0] userRdata
);
   // Unused upper bits are programmed as erased ones
   always_comb begin
      storeWdata = ufss_pkg::ERASED_WORD;
      storeWdata[USER_W-1:0] = userWdata;
      userRdata = storeRdata[USER_W-1:0];
   end
endmodule // ufss_width_adapt

// ---- sim/tb_top.sv ----
// Self-checking bench for the flash store access logic.
// Assumes the user model drives every serial frame.
`timescale 1ns/1ps
module tb_top;
   logic ref_clk, rst_n, serEn, serIn, serOut, serOutValid, busy;
   logic [8:0] curAddr;
   logic serEn8, serIn8, serOut8, serOutValid8, busy8;
   logic [8:0] curAddr8;
   logic [15:0] rd;
   int err_total, comparisons;
   ufss_store #(.USER_W(16)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .serEn(serEn), .serIn(serIn), .serOut(serOut),
      .serOutValid(serOutValid), .busy(busy), .curAddr(curAddr));
   ufss_user_model user_u (.ref_clk(ref_clk), .serEn(serEn),
      .serIn(serIn), .serOut(serOut), .serOutValid(serOutValid),
      .busy(busy));
   // Narrow user width instance
   ufss_store #(.USER_W(8)) dut8_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .serEn(serEn8), .serIn(serIn8), .serOut(serOut8),
      .serOutValid(serOutValid8), .busy(busy8), .curAddr(curAddr8));
   ufss_user_model user8_u (.ref_clk(ref_clk), .serEn(serEn8),
      .serIn(serIn8), .serOut(serOut8), .serOutValid(serOutValid8),
      .busy(busy8));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic run(input logic [1:0] op, input logic [15:0] pay);
      logic ok;
      user_u.xfer(op, pay, rd, ok);
      chk("idle after op", 16'h0001, {15'h0000, ok});
   endtask
   task automatic t_reset();
      chk("reset state", 16'h0000, {busy, serOutValid, 5'h00, curAddr});
   endtask
   task automatic t_wrap();
      run(ufss_pkg::CMD_SETADDR, 16'h01ff);
      run(ufss_pkg::CMD_ERASE, 16'h0000);
      chk("addr after erase", 16'h01ff, {7'h00, curAddr});
      run(ufss_pkg::CMD_PROG, 16'h5a3c);
      chk("addr wrap", 16'h0000, {7'h00, curAddr});
   endtask
   task automatic t_sector0();
      run(ufss_pkg::CMD_SETADDR, 16'h00ff);
      run(ufss_pkg::CMD_ERASE, 16'h0000);
      run(ufss_pkg::CMD_PROG, 16'ha5c3);
      chk("addr step", 16'h0100, {7'h00, curAddr});
   endtask
   task automatic t_readback();
      run(ufss_pkg::CMD_SETADDR, 16'h00ff);
      run(ufss_pkg::CMD_READ, 16'h0000);
      chk("read 0ff", 16'ha5c3, rd);
      run(ufss_pkg::CMD_READ, 16'h0000);
      chk("read 100", 16'hffff, rd);
      run(ufss_pkg::CMD_SETADDR, 16'h01ff);
      run(ufss_pkg::CMD_READ, 16'h0000);
      chk("other sector kept", 16'h5a3c, rd);
   endtask
   task automatic t_and();
      run(ufss_pkg::CMD_SETADDR, 16'h0100);
      run(ufss_pkg::CMD_PROG, 16'h0ff0);
      run(ufss_pkg::CMD_SETADDR, 16'h0100);
      run(ufss_pkg::CMD_PROG, 16'h3c3c);
      run(ufss_pkg::CMD_SETADDR, 16'h0100);
      run(ufss_pkg::CMD_READ, 16'h0000);
      chk("program ands", 16'h0c30, rd);
      chk("addr after read", 16'h0101, {7'h00, curAddr});
   endtask
   // Eight-bit user width: upper bits erased, read zero-extended
   task automatic t_narrow();
      logic ok;
      user8_u.xfer(ufss_pkg::CMD_ERASE, 16'h0000, rd, ok);
      user8_u.xfer(ufss_pkg::CMD_PROG, 16'h1234, rd, ok);
      chk("narrow addr", 16'h0001, {7'h00, curAddr8});
      user8_u.xfer(ufss_pkg::CMD_SETADDR, 16'h0000, rd, ok);
      user8_u.xfer(ufss_pkg::CMD_READ, 16'h0000, rd, ok);
      chk("narrow read", 16'h0034, rd);
      chk("narrow idle", 16'h0001, {15'h0000, ok});
   endtask
   task automatic summarize();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      err_total = 0;
      comparisons = 0;
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      t_reset();
      t_wrap();
      t_sector0();
      t_readback();
      t_and();
      t_narrow();
      summarize();
   end
   initial begin
      #400us;
      err_total++;
      summarize();
   end
endmodule // tb_top

// ---- sim/ufss_user_model.sv ----
// User logic model that drives the serial port of the flash store.
// Assumes the bench calls xfer only while the store is idle.
`timescale 1ns/1ps
module ufss_user_model (
   // Clock
   input wire logic ref_clk,
   // Serial port
   output logic serEn,
   output logic serIn,
   input wire logic serOut,
   input wire logic serOutValid,
   input wire logic busy
);
   initial begin
      serEn = 1'b0;
      serIn = 1'b0;
   end
   task automatic xfer(input logic [1:0] op, input logic [15:0] pay,
         output logic [15:0] rd, output logic ok);
      logic [17:0] frame;
      frame = {op, pay};
      rd = 16'h0000;
      for (int i = 17; i >= 0; i--) begin
         @(negedge ref_clk);
         serEn = 1'b1;
         serIn = frame[i];
      end
      @(negedge ref_clk);
      serEn = 1'b0;
      // Released line shows the inverse, not the last bit
      serIn = ~frame[0];
      // Keep sampling until the last read bit has gone by
      for (int n = 0; n < 100 && (busy !== 1'b0 ||
            serOutValid === 1'b1); n++) begin
         if (serOutValid === 1'b1) begin
            rd = {rd[14:0], serOut};
         end
         @(negedge ref_clk);
      end
      ok = (busy === 1'b0);
   endtask
endmodule // ufss_user_model
